// ==== inc/ssp_cfg.svh ====
// Purpose: constants of the synchronous 72-bit static RAM port
// Assumes: included by the package and by design files
// Notes: eight lanes of eight data bits plus one parity bit
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// geometry
`define SSP_ADDR_W 18
`define SSP_LANES 8
`define SSP_BYTE_W 8
`define SSP_LANE_W 9
`define SSP_DATA_W 64
`define SSP_WORD_W 72
`define SSP_BURST_W 2

// reset values
`define SSP_RST_LOW 2'h0
`define SSP_RST_BW 8'hFF
`define SSP_RST_BIT 1'h0

`endif

// ==== inc/ssp_pkg.sv ====
// Purpose: types and helpers of the synchronous 72-bit static RAM port
// Assumes: ssp_cfg.svh on the include path
// Notes: operation codes are one-hot
`include "ssp_cfg.svh"

package ssp_pkg;

  typedef enum logic [2:0] {
    SSP_OP_IDLE  = 3'h1,
    SSP_OP_READ  = 3'h2,
    SSP_OP_WRITE = 3'h4
  } ssp_op_t;

  // per-lane parity; odd selects odd parity
  function automatic logic [`SSP_LANES-1:0] ssp_lane_par(
    input logic [`SSP_DATA_W-1:0] d,
    input logic odd
  );
    logic [`SSP_LANES-1:0] p;
    p = '0;
    for (int i = 0; i < `SSP_LANES; i++) begin
      p[i] = (^d[i*`SSP_BYTE_W +: `SSP_BYTE_W]) ^ odd;
    end
    return p;
  endfunction : ssp_lane_par

endpackage : ssp_pkg

// ==== hdl/ssp_mem.sv ====
// Purpose: word array with lane write mask and registered read data
// Assumes: one write and one read port, same clock
// Notes: read data register updates only on re
`timescale 1ns/1ns

module ssp_mem #(
  parameter int AW = 18,
  parameter int LN = 8,
  parameter int LW = 9
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // write port
  input wire logic we,
  input wire logic [LN-1:0] wmask,
  input wire logic [AW-1:0] waddr,
  input wire logic [LN*LW-1:0] wdata,
  // read port
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [LN*LW-1:0] rdata
);

  logic [LN*LW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge mclk) begin
    if (we) begin
      for (int i = 0; i < LN; i++) begin
        if (wmask[i]) begin
          mem[waddr][i*LW +: LW] <= wdata[i*LW +: LW];
        end
      end
    end
  end

  // a write and a read of one word in the same edge return old data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (re) begin
      rdata <= mem[raddr];
    end
  end

endmodule : ssp_mem

// ==== hdl/ssp_burst.sv ====
// Purpose: two-bit burst address counter, linear or interleaved
// Assumes: order select is static
// Notes: next_low is combinational, the caller registers it
`timescale 1ns/1ns
`include "ssp_cfg.svh"

module ssp_burst (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic load,
  input wire logic step,
  input wire logic interleave,
  input wire logic [`SSP_BURST_W-1:0] base_low,
  // result
  output logic [`SSP_BURST_W-1:0] next_low
);

  logic [`SSP_BURST_W-1:0] base_r;
  logic [`SSP_BURST_W-1:0] cnt_r;
  logic [`SSP_BURST_W-1:0] cnt_nxt;

  // wraps inside the group of four
  assign cnt_nxt = `SSP_BURST_W'(cnt_r + 2'h1);

  always_comb begin
    if (load) begin
      next_low = base_low;
    end else if (interleave) begin
      next_low = base_r ^ cnt_nxt; // RQ17
    end else begin
      next_low = `SSP_BURST_W'(base_r + cnt_nxt); // RQ17
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      base_r <= `SSP_RST_LOW;
      cnt_r <= `SSP_RST_LOW;
    end else if (run && load) begin
      base_r <= base_low;
      cnt_r <= `SSP_RST_LOW;
    end else if (run && step) begin
      cnt_r <= cnt_nxt; // RQ15
    end
  end

endmodule : ssp_burst

// ==== hdl/ssp_top.sv ====
// Purpose: synchronous 72-bit static RAM port with no turnaround cycle
// Assumes: controller logic runs on mclk; mode and order pins are static
// Notes: late writes line up write data with read data, so no dead cycle
`timescale 1ns/1ns
`include "ssp_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// RQ1: address, data and controls are sampled only on the rising mclk edge.
// RQ2: output enable deasserted turns data drivers off at once, unclocked.
// RQ3: writes start on the clock edge and are timed internally.
// RQ4: pipelined reads pass an output register, driven one edge later.
// RQ5: reads and writes follow in any order on consecutive cycles.
// RQ6: sleep request powers down immediately, without a clock edge.
// RQ7: only lanes with an active byte strobe are written, 9 bits each.
// RQ8: three chip selects; a cycle is selected only when all are active.
// RQ9: burst order select is held static by the controller.
// RQ10: write data parity is checked, even or odd as configured.
// RQ11: parity is generated internally, stored, and read errors flagged.
// RQ12: mode select gives 3-1-1-1 pipelined or 2-1-1-1 flow-through bursts.
// RQ13: selected when first and third selects low and second high.
// RQ14: clock enable deasserted suspends all internal operations; the strap flops and write_parity_err keep updating.
// RQ15: burst step high advances the burst counter instead of loading.
// RQ16: flow-through select low means flow-through, high means pipelined.
// RQ17: burst counter wraps on the two low address bits, linear or interleaved.
module ssp_top
  import ssp_pkg::*;
#(
  parameter int ADDR_W = `SSP_ADDR_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // synchronous controls
  input wire logic clk_enable_n,
  input wire logic chip_select_first_n,
  input wire logic chip_select_second,
  input wire logic chip_select_third_n,
  input wire logic write_n,
  input wire logic [`SSP_LANES-1:0] byte_write_n,
  input wire logic burst_step,
  // address
  input wire logic [ADDR_W-3:0] addr_upper,
  input wire logic burst_addr_low1,
  input wire logic burst_addr_low0,
  // asynchronous controls
  input wire logic output_enable_n,
  input wire logic sleep_request,
  // static configuration
  input wire logic flow_through_select_n,
  input wire logic burst_order_select_n,
  input wire logic parity_odd,
  // data pins
  input wire logic [`SSP_DATA_W-1:0] data_lane_in,
  output logic [`SSP_DATA_W-1:0] data_lane_out,
  output logic data_lane_oe,
  input wire logic [`SSP_LANES-1:0] parity_lane_in,
  output logic [`SSP_LANES-1:0] parity_lane_out,
  output logic parity_lane_oe,
  // status
  output logic write_parity_err,
  output logic read_parity_err,
  output logic sleeping
);

  ////////////////////////////////////////////////////////////////////////////////
  // configuration straps, two flops each

  logic [2:0] cfg_meta_r;
  logic [2:0] cfg_r;
  logic pipe_mode;
  logic interleave;
  logic odd_sel;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_meta_r <= 3'h0;
      cfg_r <= 3'h0;
    end else begin
      cfg_meta_r <= {parity_odd, burst_order_select_n, flow_through_select_n};
      cfg_r <= cfg_meta_r;
    end
  end

  assign pipe_mode = cfg_r[0]; // RQ16
  assign interleave = cfg_r[1];
  assign odd_sel = cfg_r[2];

  ////////////////////////////////////////////////////////////////////////////////
  // cycle acceptance

  logic run;
  logic selected;
  logic acc_rd;
  logic acc_wr;

  // gating the logic rather than the clock keeps one clean clock tree
  assign run = ~clk_enable_n & ~sleep_request; // RQ14 RQ6
  assign selected = ~chip_select_first_n & chip_select_second & ~chip_select_third_n; // RQ8 RQ13
  assign acc_rd = selected & ~burst_step & write_n;
  assign acc_wr = selected & ~burst_step & ~write_n;

  ////////////////////////////////////////////////////////////////////////////////
  // burst counter

  logic [`SSP_BURST_W-1:0] next_low;

  ssp_burst u_burst (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(run),
    .load(selected & ~burst_step),
    .step(burst_step),
    .interleave(interleave),
    .base_low({burst_addr_low1, burst_addr_low0}),
    .next_low(next_low)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // address and control pipeline

  ssp_op_t s1_op_r;
  ssp_op_t s2_op_r;
  logic [ADDR_W-1:0] s1_addr_r;
  logic [ADDR_W-1:0] s2_addr_r;
  logic [`SSP_LANES-1:0] s1_bw_r;
  logic [`SSP_LANES-1:0] s2_bw_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_op_r <= SSP_OP_IDLE;
      s1_addr_r <= '0;
      s1_bw_r <= `SSP_RST_BW;
    end else if (run) begin // RQ1
      s1_bw_r <= byte_write_n;
      if (burst_step) begin
        s1_addr_r <= {s1_addr_r[ADDR_W-1:2], next_low}; // RQ15
      end else if (selected) begin
        s1_op_r <= write_n ? SSP_OP_READ : SSP_OP_WRITE; // RQ5
        s1_addr_r <= {addr_upper, next_low};
      end else begin
        s1_op_r <= SSP_OP_IDLE; // RQ8
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s2_op_r <= SSP_OP_IDLE;
      s2_addr_r <= '0;
      s2_bw_r <= `SSP_RST_BW;
    end else if (run) begin
      s2_op_r <= s1_op_r;
      s2_addr_r <= s1_addr_r;
      s2_bw_r <= s1_bw_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // late write: data one edge after address in flow-through, two in pipelined

  logic wr_fire;
  logic [ADDR_W-1:0] wr_addr;
  logic [`SSP_LANES-1:0] wr_bw;
  logic [`SSP_LANES-1:0] wr_par;
  logic [`SSP_WORD_W-1:0] wr_word;

  always_comb begin
    case (pipe_mode)
      1'b1: begin
        wr_fire = run & (s2_op_r == SSP_OP_WRITE); // RQ3
        wr_addr = s2_addr_r;
        wr_bw = s2_bw_r;
      end
      default: begin
        wr_fire = run & (s1_op_r == SSP_OP_WRITE); // RQ3
        wr_addr = s1_addr_r;
        wr_bw = s1_bw_r;
      end
    endcase
  end

  // stored parity is generated here, never taken from the pins
  assign wr_par = ssp_lane_par(data_lane_in, odd_sel); // RQ11

  always_comb begin
    wr_word = '0;
    for (int i = 0; i < `SSP_LANES; i++) begin
      wr_word[i*`SSP_LANE_W +: `SSP_LANE_W] = {wr_par[i], data_lane_in[i*`SSP_BYTE_W +: `SSP_BYTE_W]};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      write_parity_err <= `SSP_RST_BIT;
    end else begin
      write_parity_err <= wr_fire & (|((wr_par ^ parity_lane_in) & ~wr_bw)); // RQ10
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // storage and read path

  logic [`SSP_WORD_W-1:0] mem_rdata;
  logic [`SSP_WORD_W-1:0] out_word_r;
  logic rd1_valid_r;
  logic out_valid_r;
  logic rd_issue;
  logic [ADDR_W-1:0] rd_addr;

  // the array is read at the accepting edge, so read data never meets late write data
  assign rd_issue = run & (burst_step ? (s1_op_r == SSP_OP_READ) : acc_rd); // RQ5
  assign rd_addr = burst_step ? {s1_addr_r[ADDR_W-1:2], next_low} : {addr_upper, next_low};

  // pipelined write-then-read of one word within two cycles returns old data
  ssp_mem #(
    .AW(ADDR_W),
    .LN(`SSP_LANES),
    .LW(`SSP_LANE_W)
  ) u_mem (
    .mclk(mclk),
    .rst_n(rst_n),
    .we(wr_fire),
    .wmask(~wr_bw), // RQ7
    .waddr(wr_addr),
    .wdata(wr_word),
    .re(rd_issue),
    .raddr(rd_addr),
    .rdata(mem_rdata)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd1_valid_r <= `SSP_RST_BIT;
    end else if (run) begin
      rd1_valid_r <= rd_issue; // RQ12
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_r <= `SSP_RST_BIT;
      out_word_r <= '0;
    end else if (run) begin
      out_valid_r <= rd1_valid_r; // RQ4
      out_word_r <= mem_rdata; // RQ4
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pins

  logic drive_sel;
  logic [`SSP_WORD_W-1:0] vis_word;
  logic [`SSP_DATA_W-1:0] vis_data;
  logic [`SSP_LANES-1:0] vis_par;

  assign drive_sel = pipe_mode ? out_valid_r : rd1_valid_r; // RQ12
  assign vis_word = pipe_mode ? out_word_r : mem_rdata;

  always_comb begin
    vis_data = '0;
    vis_par = '0;
    for (int i = 0; i < `SSP_LANES; i++) begin
      vis_data[i*`SSP_BYTE_W +: `SSP_BYTE_W] = vis_word[i*`SSP_LANE_W +: `SSP_BYTE_W];
      vis_par[i] = vis_word[i*`SSP_LANE_W + `SSP_BYTE_W];
    end
  end

  assign data_lane_out = vis_data;
  assign parity_lane_out = vis_par;
  // output enable and sleep gate drive_sel unclocked, so the drivers drop without waiting for mclk
  assign data_lane_oe = drive_sel & ~output_enable_n & ~sleep_request; // RQ2 RQ6
  assign parity_lane_oe = drive_sel & ~output_enable_n & ~sleep_request; // RQ2 RQ6
  assign read_parity_err = drive_sel & (|(ssp_lane_par(vis_data, odd_sel) ^ vis_par)); // RQ11
  assign sleeping = sleep_request; // RQ6

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_addr_capture: assert property ( // RQ1
    run && selected && !burst_step |=> s1_addr_r == $past({addr_upper, burst_addr_low1,
      burst_addr_low0})
  ) else $error("address not captured on the accepting edge");

  chk_oe_async_off: assert property ( // RQ2
    output_enable_n |-> !data_lane_oe && !parity_lane_oe
  ) else $error("drivers on while output enable deasserted");

  chk_ft_write_lanes: assert property ( // RQ7
    (acc_wr && run) ##1 (!pipe_mode && run) |-> wr_fire && (~wr_bw == $past(~byte_write_n))
  ) else $error("flow-through write not issued with its lane mask");

  chk_pipe_write_late: assert property ( // RQ3
    (acc_wr && run) ##1 (pipe_mode && run) ##1 run |-> wr_fire && wr_addr == $past(s1_addr_r)
  ) else $error("pipelined write not issued two edges after address");

  chk_pipe_read_lat: assert property ( // RQ4
    (acc_rd && run && pipe_mode) ##1 (pipe_mode && run) |=> drive_sel
  ) else $error("pipelined read data not driven on the third cycle");

  chk_ft_read_lat: assert property ( // RQ12
    (acc_rd && run && !pipe_mode) |=> drive_sel
  ) else $error("flow-through read data not driven on the second cycle");

  chk_rw_back: assert property ( // RQ5
    (acc_rd && run) ##1 (acc_wr && run) |=> s1_op_r == SSP_OP_WRITE && $past(s1_op_r) ==
      SSP_OP_READ
  ) else $error("read then write not accepted back to back");

  chk_sleep_off: assert property ( // RQ6
    sleep_request |-> !data_lane_oe && !parity_lane_oe && sleeping
  ) else $error("drivers on during sleep");

  chk_deselect_idle: assert property ( // RQ8
    run && !selected && !burst_step |=> s1_op_r == SSP_OP_IDLE
  ) else $error("deselected cycle started an operation");

  chk_wpar_source: assert property ( // RQ10
    write_parity_err |-> $past(wr_fire)
  ) else $error("write parity flag without a write");

  chk_cke_hold: assert property ( // RQ14
    clk_enable_n |=> $stable(s1_op_r) && $stable(rd1_valid_r) && $stable(out_valid_r)
  ) else $error("state moved while clock enable deasserted");

  chk_burst_advance: assert property ( // RQ15
    run && burst_step |=> s1_addr_r[ADDR_W-1:2] == $past(s1_addr_r[ADDR_W-1:2]) &&
      s1_addr_r[1:0] != $past(s1_addr_r[1:0])
  ) else $error("burst step did not advance the low address bits");

  cov_pipe_read: cover property (
    (acc_rd && run && pipe_mode) ##1 run ##1 drive_sel
  );

  cov_read_write_read: cover property (
    (acc_rd && run) ##1 (acc_wr && run) ##1 (acc_rd && run)
  );

  cov_burst_four: cover property (
    (acc_rd && run) ##1 (run && burst_step) [*3]
  );

endmodule : ssp_top

// ==== bench/ssp_bus_model.sv ====
// Purpose: controller side of the shared data and parity pins
// Assumes: the device drives only while its enable is high
// Notes: a released bus shows the inverse of its last value, never a held copy
`timescale 1ns/1ns

module ssp_bus_model (
  // clock
  input wire logic mclk,
  // device side
  input wire logic [63:0] dev_data,
  input wire logic [7:0] dev_par,
  input wire logic dev_oe,
  // controller side
  input wire logic ctl_drive,
  input wire logic [63:0] ctl_data,
  input wire logic [7:0] ctl_par,
  // resolved pins
  output logic [63:0] bus_data,
  output logic [7:0] bus_par
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [71:0] last_r = '0;

  always_comb begin
    if (dev_oe) begin
      {bus_par, bus_data} = {dev_par, dev_data};
    end else if (ctl_drive) begin
      {bus_par, bus_data} = {ctl_par, ctl_data};
    end else begin
      {bus_par, bus_data} = ~last_r;
    end
  end

  // inverse of the last level so a stale copy can never pass for data
  always_ff @(posedge mclk) begin
    if (dev_oe || ctl_drive) begin
      last_r <= {bus_par, bus_data};
    end
  end
endmodule : ssp_bus_model

// ==== bench/testbench.sv ====
// Purpose: self-checking bench of the synchronous static RAM port
// Assumes: small address width; a model memory predicts every read
// Notes: the schedule counts running edges only, as the device does
`timescale 1ns/1ns

module testbench;
  ////////////////////////////////////////////////////////////////////////////////
  localparam int AW = 6;
  localparam int LIMIT = 2000;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic cken_n = 1'b0;
  logic cs1_n = 1'b1;
  logic cs2 = 1'b0;
  logic cs3_n = 1'b1;
  logic wr_n = 1'b1;
  logic [7:0] bw_n = 8'hFF;
  logic step = 1'b0;
  logic [AW-1:0] adr = '0;
  logic oe_n = 1'b0;
  logic sleep = 1'b0;
  logic ft_n = 1'b1;
  logic lbo_n = 1'b0;
  logic podd = 1'b0;
  logic drv = 1'b0;
  logic [63:0] wdat = '0;
  logic [7:0] wpar = '0;
  logic [63:0] din;
  logic [63:0] dout;
  logic [7:0] pin;
  logic [7:0] pout;
  logic doe;
  logic poe;
  logic werr;
  logic rerr;
  logic slp;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  int t = 0;
  int lat = 2;
  int lastop = 0;
  logic [AW-1:0] base = '0;
  logic [1:0] k = 2'h0;
  logic [7:0] pat = 8'h01;
  logic [71:0] mem [64];
  logic rv [8] = '{default: 1'b0};
  logic ev [8] = '{default: 1'b0};
  logic wv [8] = '{default: 1'b0};
  logic [71:0] re [8];
  logic [71:0] wd [8] = '{default: '0};

  ssp_top #(.ADDR_W(AW)) i_ssp_top (.mclk(mclk), .rst_n(rst_n), .clk_enable_n(cken_n),
    .chip_select_first_n(cs1_n), .chip_select_second(cs2), .chip_select_third_n(cs3_n),
    .write_n(wr_n), .byte_write_n(bw_n), .burst_step(step), .addr_upper(adr[AW-1:2]),
    .burst_addr_low1(adr[1]), .burst_addr_low0(adr[0]), .output_enable_n(oe_n),
    .sleep_request(sleep), .flow_through_select_n(ft_n), .burst_order_select_n(lbo_n),
    .parity_odd(podd), .data_lane_in(din), .data_lane_out(dout), .data_lane_oe(doe),
    .parity_lane_in(pin), .parity_lane_out(pout), .parity_lane_oe(poe),
    .write_parity_err(werr), .read_parity_err(rerr), .sleeping(slp));

  ssp_bus_model i_ssp_bus_model (.mclk(mclk), .dev_data(dout), .dev_par(pout), .dev_oe(doe),
    .ctl_drive(drv), .ctl_data(wdat), .ctl_par(wpar), .bus_data(din), .bus_par(pin));

  ////////////////////////////////////////////////////////////////////////////////
  always #4 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      results();
    end
  end

  function automatic logic [7:0] par8(input logic [63:0] d, input logic odd);
    logic [7:0] p;
    for (int i = 0; i < 8; i++) begin
      p[i] = ^{odd, d[8*i +: 8]};
    end
    return p;
  endfunction : par8

  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one clock of controller traffic; frozen edges move nothing in the schedule
  task automatic tick(input logic [2:0] cs, input logic w, input logic s,
                      input logic [AW-1:0] a, input logic [7:0] bw, input logic [7:0] bad,
                      input logic hold);
    int i;
    logic [AW-1:0] ea;
    logic [63:0] d;
    logic [7:0] p;
    @(posedge mclk);
    if (cken_n === 1'b0) begin
      i = t % 8;
      if (rv[i]) begin
        chk({pout, dout}, re[i]);
        chk({rerr, doe, poe}, 3'b011);
      end else begin
        chk({doe, poe}, 2'b00);
      end
      chk(werr, ev[i]);
      drv <= wv[i];
      wdat <= wd[i][63:0];
      wpar <= wd[i][71:64];
      rv[i] = 1'b0;
      ev[i] = 1'b0;
      wv[i] = 1'b0;
      if (s && lastop != 0) begin
        k = k + 2'h1;
        ea = {base[AW-1:2], lbo_n ? base[1:0] ^ k : base[1:0] + k};
      end else begin
        lastop = (cs == 3'b010 && !s) ? (w ? 1 : 2) : 0;
        base = a;
        k = 2'h0;
        ea = a;
      end
      if (lastop == 1) begin
        rv[(t + lat + 1) % 8] = 1'b1;
        re[(t + lat + 1) % 8] = mem[ea];
      end else if (lastop == 2) begin
        d = 64'h0F1E2D3C4B5A6978 ^ {8{pat}};
        pat = pat + 8'h3B;
        p = par8(d, podd);
        wv[(t + lat) % 8] = 1'b1;
        wd[(t + lat) % 8] = {p ^ bad, d};
        ev[(t + lat + 2) % 8] = |(bad & ~bw);
        for (int n = 0; n < 8; n++) begin
          if (!bw[n]) begin
            mem[ea][64+n] = p[n];
            mem[ea][8*n +: 8] = d[8*n +: 8];
          end
        end
      end
      t++;
    end
    {cs1_n, cs2, cs3_n} <= cs;
    wr_n <= w;
    step <= s;
    adr <= a;
    bw_n <= bw;
    cken_n <= hold;
  endtask : tick

  task automatic idle(input int n);
    repeat (n) tick(3'b000, 1'b1, 1'b0, '0, 8'hFF, 8'h00, 1'b0);
  endtask : idle

  task automatic rd(input int a);
    tick(3'b010, 1'b1, 1'b0, AW'(a), 8'hFF, 8'h00, 1'b0);
  endtask : rd

  task automatic wr(input int a, input logic [7:0] bw, input logic [7:0] bad);
    tick(3'b010, 1'b0, 1'b0, AW'(a), bw, bad, 1'b0);
  endtask : wr

  // asynchronous pins are pulsed between edges, never seen by a clock edge
  task automatic poke(input logic which);
    #2;
    if (which) sleep = 1'b1;
    else oe_n = 1'b1;
    #1;
    chk({slp, doe, poe}, {which, 2'b00});
    sleep = 1'b0;
    oe_n = 1'b0;
    #1;
    chk(doe, 1'b1);
  endtask : poke

  task automatic results();
    if (mismatches == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      ft_n <= m[0];
      lbo_n <= m[1];
      podd <= m[0] ^ m[1];
      lat = m[0] ? 2 : 1;
      idle(5);
      for (int a = 0; a < 6; a++) wr(a, 8'h00, 8'h00);
      rd(0);
      wr(4, 8'h0F, 8'h10);
      rd(1);
      wr(5, 8'hF0, 8'h80);
      rd(2);
      rd(3);
      idle(3);
      rd(4);
      rd(5);
      for (int c = 0; c < 8; c++) tick(3'(c), 1'b0, 1'b0, 6'h08, 8'h00, 8'h00, 1'b0);
      idle(3);
      for (int c = 0; c < 8; c++) tick(3'(c), 1'b1, 1'b0, 6'h08, 8'hFF, 8'h00, 1'b0);
      wr(13, 8'h00, 8'h00);
      repeat (3) tick(3'b010, 1'b0, 1'b1, '0, 8'h00, 8'h00, 1'b0);
      idle(3);
      rd(2);
      repeat (3) tick(3'b010, 1'b1, 1'b1, '0, 8'hFF, 8'h00, 1'b0);
      for (int a = 12; a < 16; a++) rd(a);
      rd(1);
      repeat (3) tick(3'b000, 1'b1, 1'b0, '0, 8'hFF, 8'h00, 1'b1);
      tick(3'b000, 1'b1, 1'b0, '0, 8'hFF, 8'h00, 1'b0);
      idle(4);
      rd(0);
      idle(lat);
      poke(1'b0);
      idle(2);
      rd(1);
      idle(lat);
      poke(1'b1);
      idle(6);
    end
    results();
  end
endmodule : testbench
